// *** pkg/frame_router_regs.svh ***
`ifndef FRAME_ROUTER_REGS_SVH
`define FRAME_ROUTER_REGS_SVH
// Port numbers of the slave protocol controller
`define PORT_UP 2'h0
`define PORT_TERM 2'h1
`define PORT_DOWN 2'h2
`define PORT_PROC 2'h3
// Broadcast destination and protocol type of accepted frames
`define BCAST_MAC 48'hFFFFFFFFFFFF
`define FIELDBUS_ETYPE 16'h88A4
// Header length in bytes before payload starts
`define HDR_LEN 4'hE
`define DST_END 4'h6
`define TYPE_HI 4'hC
`define TYPE_LO 4'hD
// Station identifier layout within the payload
`define ID_BYTE_LO 4'h0
`define ID_BYTE_HI 4'h1
`define ID_MAX 12'hFFF
`endif

// *** pkg/frame_router_pkg.sv ***
package frame_router_pkg;
   typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} esm_e;
   typedef enum logic [1:0] {FR_IDLE, FR_HDR, FR_PASS, FR_DROP} frame_e;
   typedef logic [7:0] byte_t;
   typedef logic [11:0] station_id_t;
endpackage : frame_router_pkg

// *** verilog/skid_buffer.sv ***
module skid_buffer (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [8:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [8:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   typedef struct packed {
      logic [1:0][8:0] mem;
      logic rd;
      logic wr;
      logic [1:0] cnt;
   } skid_s;

   skid_s st_ff;
   skid_s nxt_st;
   logic push;
   logic pop;

   assign in_ready = (st_ff.cnt != 2'h2);
   assign out_valid = (st_ff.cnt != 2'h0);
   assign out_data = st_ff.mem[st_ff.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_data;
         nxt_st.wr = ~st_ff.wr;
      end
      if (pop) begin
         nxt_st.rd = ~st_ff.rd;
      end
      case ({push, pop})
         2'b10: nxt_st.cnt = st_ff.cnt + 2'h1;
         2'b01: nxt_st.cnt = st_ff.cnt - 2'h1;
         default: nxt_st.cnt = st_ff.cnt;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : skid_buffer

// *** verilog/coupler_frame_port_router.sv ***
`include "frame_router_regs.svh"

module coupler_frame_port_router (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] up_rx_data,
   input wire logic up_rx_valid,
   input wire logic up_rx_last,
   output logic [7:0] up_tx_data,
   output logic up_tx_valid,
   output logic up_tx_last,
   output logic [7:0] term_tx_data,
   output logic term_tx_valid,
   output logic term_tx_last,
   input wire logic term_tx_ready,
   input wire logic [7:0] term_rx_data,
   input wire logic term_rx_valid,
   input wire logic term_rx_last,
   output logic [7:0] down_tx_data,
   output logic down_tx_valid,
   output logic down_tx_last,
   input wire logic [7:0] down_rx_data,
   input wire logic down_rx_valid,
   input wire logic down_rx_last,
   input wire logic term_link,
   input wire logic down_link,
   input wire logic [3:0] id_switch_hi,
   input wire logic [3:0] id_switch_mid,
   input wire logic [3:0] id_switch_lo,
   input wire logic id_enable,
   input wire logic [1:0] esm_request,
   output logic [1:0] esm_state,
   output logic frame_dropped,
   output logic up_rx_ready
);
   typedef struct packed {
      logic [1:0] term_link_meta;
      logic [1:0] term_link_sync;
      logic [1:0] down_link_meta;
      logic [1:0] down_link_sync;
      logic [11:0] sw_meta;
      logic [11:0] sw_sync;
      frame_router_pkg::esm_e esm;
      frame_router_pkg::frame_e fr;
      logic [3:0] hdr_cnt;
      logic is_bcast;
      logic [7:0] type_hi;
      logic [7:0] up_data;
      logic up_valid;
      logic up_last;
      logic [7:0] dn_data;
      logic dn_valid;
      logic dn_last;
      logic dropped;
      logic [7:0] pay_cnt;
      logic [8:0] term_data;
      logic term_v;
      logic rx_ready;
   } route_s;

   route_s st_ff;
   route_s nxt_st;
   logic [8:0] buf_in_data;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [8:0] buf_out_data;
   logic buf_out_valid;
   logic buf_out_ready;
   logic buf_full_next;
   logic [11:0] id_raw;
   frame_router_pkg::byte_t proc_byte;

   // Substitute station identifier byte into process data payload
   function automatic frame_router_pkg::byte_t id_insert(input frame_router_pkg::byte_t b,
         input logic [7:0] pos, input logic [11:0] id, input logic en);
      id_insert = b;
      if (en && pos == {4'h0, `ID_BYTE_LO}) begin
         id_insert = id[7:0];
      end else if (en && pos == {4'h0, `ID_BYTE_HI}) begin
         id_insert = {4'h0, id[11:8]};
      end
   endfunction : id_insert

   assign id_raw = {id_switch_hi, id_switch_mid, id_switch_lo};

   skid_buffer u_buf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_data(buf_in_data),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .out_data(buf_out_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready)
   );

   always_comb begin
      proc_byte = up_rx_data;
      if (st_ff.esm == frame_router_pkg::ST_OP || st_ff.esm == frame_router_pkg::ST_SAFEOP) begin
         proc_byte = id_insert(up_rx_data, st_ff.pay_cnt, st_ff.sw_sync, id_enable);
      end
   end

   // port 0 into processing unit; processing ends at closed port 3 then port 1
   assign buf_in_valid = up_rx_valid && up_rx_ready && st_ff.fr == frame_router_pkg::FR_PASS && st_ff.term_link_sync[1];
   assign buf_in_data = {up_rx_last, proc_byte};
   assign buf_out_ready = term_tx_ready || !st_ff.term_v;
   // Ready is registered, so it must already promise room for a byte taken next cycle
   assign buf_full_next = (!buf_in_ready || (buf_out_valid && buf_in_valid)) && !(buf_out_valid && buf_out_ready);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.term_link_meta = {st_ff.term_link_meta[0], term_link};
      nxt_st.term_link_sync = {st_ff.term_link_sync[0], st_ff.term_link_meta[1]};
      nxt_st.down_link_meta = {st_ff.down_link_meta[0], down_link};
      nxt_st.down_link_sync = {st_ff.down_link_sync[0], st_ff.down_link_meta[1]};
      nxt_st.sw_meta = id_raw;
      nxt_st.sw_sync = st_ff.sw_meta & `ID_MAX;
      // state advances only by master request
      nxt_st.esm = frame_router_pkg::esm_e'(esm_request);
      nxt_st.dropped = 1'b0;
      // parse header on open port 0
      if (up_rx_valid && up_rx_ready) begin
         case (st_ff.fr)
            frame_router_pkg::FR_IDLE,
            frame_router_pkg::FR_HDR: begin
               nxt_st.fr = frame_router_pkg::FR_HDR;
               nxt_st.hdr_cnt = st_ff.hdr_cnt + 4'h1;
               if (st_ff.hdr_cnt < `DST_END && up_rx_data != 8'hFF) begin
                  nxt_st.is_bcast = 1'b0;
               end
               if (st_ff.hdr_cnt == `TYPE_HI) begin
                  nxt_st.type_hi = up_rx_data;
               end
               if (st_ff.hdr_cnt == `TYPE_LO) begin
                  if (st_ff.is_bcast && {st_ff.type_hi, up_rx_data} == `FIELDBUS_ETYPE) begin
                     nxt_st.fr = frame_router_pkg::FR_PASS;
                  end else begin
                     nxt_st.fr = frame_router_pkg::FR_DROP;
                     nxt_st.dropped = 1'b1;
                  end
                  nxt_st.pay_cnt = 8'h00;
               end
            end
            frame_router_pkg::FR_PASS: begin
               if (st_ff.pay_cnt != 8'hFF) begin
                  nxt_st.pay_cnt = st_ff.pay_cnt + 8'h01;
               end
            end
            frame_router_pkg::FR_DROP: begin
               nxt_st.fr = frame_router_pkg::FR_DROP;
            end
            default: nxt_st.fr = frame_router_pkg::FR_IDLE;
         endcase
         if (up_rx_last) begin
            nxt_st.fr = frame_router_pkg::FR_IDLE;
            nxt_st.hdr_cnt = 4'h0;
            nxt_st.is_bcast = 1'b1;
         end
      end
      // port 1 return to port 2, out downstream when linked
      nxt_st.dn_valid = 1'b0;
      nxt_st.dn_last = 1'b0;
      nxt_st.dn_data = st_ff.dn_data;
      if (term_rx_valid && st_ff.down_link_sync[1]) begin
         nxt_st.dn_valid = 1'b1;
         nxt_st.dn_data = term_rx_data;
         nxt_st.dn_last = term_rx_last;
      end
      // port 2 back to port 0 and master; port 1 return goes there instead while port 2 is not linked
      nxt_st.up_valid = 1'b0;
      nxt_st.up_last = 1'b0;
      nxt_st.up_data = st_ff.up_data;
      if (st_ff.down_link_sync[1] && down_rx_valid) begin
         nxt_st.up_valid = 1'b1;
         nxt_st.up_data = down_rx_data;
         nxt_st.up_last = down_rx_last;
      end else if (!st_ff.down_link_sync[1] && term_rx_valid) begin
         nxt_st.up_valid = 1'b1;
         nxt_st.up_data = term_rx_data;
         nxt_st.up_last = term_rx_last;
      end
      // output stage reloads once held byte taken
      if (buf_out_ready) begin
         nxt_st.term_data = buf_out_data;
         nxt_st.term_v = buf_out_valid;
      end
      // closed terminal port: no back-pressure, frame not sent there
      nxt_st.rx_ready = !buf_full_next || !st_ff.term_link_sync[0];
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
         st_ff.is_bcast <= 1'b1;
         st_ff.esm <= frame_router_pkg::ST_INIT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign up_rx_ready = st_ff.rx_ready;
   assign term_tx_data = st_ff.term_data[7:0];
   assign term_tx_last = st_ff.term_data[8];
   assign term_tx_valid = st_ff.term_v;
   assign up_tx_data = st_ff.up_data;
   assign up_tx_valid = st_ff.up_valid;
   assign up_tx_last = st_ff.up_last;
   assign down_tx_data = st_ff.dn_data;
   assign down_tx_valid = st_ff.dn_valid;
   assign down_tx_last = st_ff.dn_last;
   assign esm_state = st_ff.esm;
   assign frame_dropped = st_ff.dropped;
endmodule : coupler_frame_port_router

// *** test/coupler_frame_port_router_props.sv ***
module coupler_frame_port_router_props (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic up_rx_ready,
   input wire logic [7:0] up_tx_data,
   input wire logic up_tx_valid,
   input wire logic [7:0] term_tx_data,
   input wire logic term_tx_valid,
   input wire logic term_tx_ready,
   input wire logic [7:0] term_rx_data,
   input wire logic term_rx_valid,
   input wire logic [7:0] down_tx_data,
   input wire logic down_tx_valid,
   input wire logic [7:0] down_rx_data,
   input wire logic down_rx_valid,
   input wire logic term_link,
   input wire logic down_link,
   input wire logic [1:0] esm_request,
   input wire logic [1:0] esm_state,
   input wire logic frame_dropped
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_init_state: assert property ($rose(rstn) |-> esm_state == 2'h0) else $error("not init");
   a_state_follow: assert property ($past(rstn) |-> esm_state == $past(esm_request)) else $error("state");
   a_down_copy: assert property (down_link [*5] ##0 term_rx_valid |=>
      down_tx_valid && down_tx_data == $past(term_rx_data)) else $error("down copy");
   a_down_skip: assert property (!down_link [*5] ##0 term_rx_valid |=>
      !down_tx_valid && up_tx_valid && up_tx_data == $past(term_rx_data)) else $error("down skip");
   a_return_up: assert property (down_link [*5] ##0 down_rx_valid |=>
      up_tx_valid && up_tx_data == $past(down_rx_data)) else $error("return up");
   a_term_quiet: assert property (!term_link [*5] |-> !term_tx_valid) else $error("term tx");
   a_ready_nolink: assert property (!term_link [*5] |=> up_rx_ready) else $error("ready");
   a_tx_hold: assert property (term_tx_valid && !term_tx_ready |=>
      term_tx_valid && $stable(term_tx_data)) else $error("tx hold");
   a_drop_pulse: assert property (frame_dropped |=> !frame_dropped) else $error("drop pulse");
endmodule : coupler_frame_port_router_props
bind coupler_frame_port_router coupler_frame_port_router_props props (.*);

// *** test/term_chain_model.sv ***
module term_chain_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] term_tx_data,
   input wire logic term_tx_valid,
   input wire logic term_tx_last,
   input wire logic stall,
   output logic term_tx_ready,
   output logic [7:0] term_rx_data,
   output logic term_rx_valid,
   output logic term_rx_last
);
   timeunit 1ns;
   timeprecision 100ps;
   assign term_tx_ready = !stall;
   // Idle data line toggles so a stale byte never looks valid
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         term_rx_valid <= 1'h0;
         term_rx_last <= 1'h0;
         term_rx_data <= 8'h00;
      end else begin
         term_rx_valid <= #1 term_tx_valid && term_tx_ready;
         term_rx_last <= #1 term_tx_last;
         term_rx_data <= #1 (term_tx_valid && term_tx_ready) ? term_tx_data : ~term_rx_data;
      end
   end
endmodule : term_chain_model

// *** test/tb_coupler_frame_port_router.sv ***
`include "frame_router_regs.svh"
module tb_coupler_frame_port_router;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'h0;
   logic rstn = 1'h0;
   logic [7:0] up_rx_data = 8'h00, down_rx_data = 8'h00;
   logic up_rx_valid = 1'h0, up_rx_last = 1'h0, down_rx_valid = 1'h0, down_rx_last = 1'h0;
   logic term_link = 1'h0, down_link = 1'h0, id_enable = 1'h1, stall = 1'h0, hold = 1'h0;
   logic [3:0] id_switch_hi = 4'h0, id_switch_mid = 4'h0, id_switch_lo = 4'h0;
   logic [1:0] esm_request = 2'h0, esm_state;
   logic [7:0] up_tx_data, term_tx_data, term_rx_data, down_tx_data;
   logic up_tx_valid, up_tx_last, term_tx_valid, term_tx_last, term_tx_ready, term_rx_valid, term_rx_last;
   logic down_tx_valid, down_tx_last, frame_dropped, up_rx_ready;
   logic [8:0] exp_q[$];
   logic [4:0] dl_hist = 5'h00;
   logic [9:0] up_exp = 10'h000, dn_exp = 10'h000;
   logic ret_chk = 1'h0;
   int error_cnt = 0, tests_run = 0, seed = 27, drops = 0;
   coupler_frame_port_router dut (.*);
   term_chain_model chain (.*);
   task automatic check(input logic [8:0] seen, input logic [8:0] expd);
      tests_run++;
      if (seen !== expd) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, seen, expd);
      end
   endtask : check
   task automatic give_verdict;
      $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic put(input logic [7:0] d, input logic l);
      up_rx_data = d;
      up_rx_last = l;
      up_rx_valid = 1'h1;
      while (up_rx_ready !== 1'h1) begin
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      #1;
   endtask : put
   task automatic frame(input logic [15:0] ty, input logic bc, input int n, input logic ins);
      logic [7:0] b;
      for (int i = 0; i < 14 + n; i++) begin
         b = $random(seed);
         if (i < 6) b = bc ? 8'hFF : 8'h02;
         if (i == 12) b = ty[15:8];
         if (i == 13) b = ty[7:0];
         put(b, i == 13 + n);
         // payload after header, id in first two bytes
         if (i > 13 && ty == `FIELDBUS_ETYPE && bc && term_link)
            exp_q.push_back({i == 13 + n, (ins && i == 14) ? {id_switch_mid, id_switch_lo} :
               (ins && i == 15) ? {4'h0, id_switch_hi} : b});
      end
   endtask : frame
   initial forever #5 clk_sys = ~clk_sys;
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
   always @(posedge clk_sys) #1 stall = hold || ({$random(seed)} % 3 == 0);
   always @(posedge clk_sys) begin
      if (frame_dropped === 1'h1) drops++;
      if (rstn && term_tx_valid && term_tx_ready)
         check({term_tx_last, term_tx_data}, exp_q.size() ? exp_q.pop_front() : 9'hXXX);
      if (ret_chk) begin
         check({8'h00, up_tx_valid}, {8'h00, up_exp[9]});
         check({8'h00, down_tx_valid}, {8'h00, dn_exp[9]});
         if (up_exp[9]) check({up_tx_last, up_tx_data}, up_exp[8:0]);
         if (dn_exp[9]) check({down_tx_last, down_tx_data}, dn_exp[8:0]);
      end
      // Only judge the return path once the downstream link has been steady for five samples
      dl_hist = {dl_hist[3:0], down_link};
      ret_chk = rstn && (&dl_hist || !(|dl_hist));
      dn_exp = (&dl_hist && term_rx_valid) ? {1'h1, term_rx_last, term_rx_data} : 10'h000;
      if (&dl_hist) up_exp = down_rx_valid ? {1'h1, down_rx_last, down_rx_data} : 10'h000;
      else up_exp = term_rx_valid ? {1'h1, term_rx_last, term_rx_data} : 10'h000;
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 rstn = 1'h1;
      check({7'h00, esm_state}, 9'h000);
      term_link = 1'h1;
      down_link = 1'h1;
      for (int s = 0; s < 4; s++) begin
         esm_request = s[1:0];
         id_enable = s != 3;
         {id_switch_hi, id_switch_mid, id_switch_lo} = $random(seed);
         repeat (5) @(posedge clk_sys);
         #1 check({7'h00, esm_state}, s[8:0]);
         frame(`FIELDBUS_ETYPE, 1'h1, 2 + {$random(seed)} % 6, s == 2);
         up_rx_valid = 1'h0;
      end
      repeat (2) @(posedge clk_sys);
      #1 hold = 1'h1;
      id_enable = 1'h1;
      fork
         begin
            frame(`FIELDBUS_ETYPE, 1'h1, 8, 1'h1);
            frame(`FIELDBUS_ETYPE, 1'h1, 3, 1'h1);
         end
      join_none
      repeat (30) @(posedge clk_sys);
      #1 check({8'h00, up_rx_ready}, 9'h000);
      hold = 1'h0;
      wait fork;
      frame(16'h0800, 1'h1, 3, 1'h0);
      frame(`FIELDBUS_ETYPE, 1'h0, 3, 1'h0);
      up_rx_valid = 1'h0;
      down_link = 1'h0;
      repeat (6) @(posedge clk_sys);
      #1 frame(`FIELDBUS_ETYPE, 1'h1, 4, 1'h1);
      up_rx_valid = 1'h0;
      repeat (20) @(posedge clk_sys);
      #1 down_link = 1'h1;
      repeat (6) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         #1 down_rx_data = $random(seed);
         down_rx_last = i == 3;
         down_rx_valid = 1'h1;
         @(posedge clk_sys);
      end
      #1 down_rx_valid = 1'h0;
      term_link = 1'h0;
      repeat (6) @(posedge clk_sys);
      #1 frame(`FIELDBUS_ETYPE, 1'h1, 4, 1'h1);
      up_rx_valid = 1'h0;
      check({8'h00, up_rx_ready}, 9'h001);
      repeat (20) @(posedge clk_sys);
      #1 check(9'(exp_q.size()), 9'h000);
      check(9'(drops), 9'h002);
      give_verdict();
   end
endmodule : tb_coupler_frame_port_router
